// ### periodic_timer_module_tb_top.sv
// self-checking bench for the periodic timer
// assumes ptm_timer, pin model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
`include "ptm_consts.vh"
module periodic_timer_module_tb_top;
   logic        aclk, aresetn, awv, wv, bready, arv, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        ext_clk, cap, tout, tout_n, fa, fp, cflag;
   logic [9:0]  cval, lastcap;
   int          mismatches, checks_done, na, np, nc, hi;
   ptm_timer #(.SUB_DIV(4)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_clock_in(ext_clk), .capture_in(cap), .timer_out(tout),
      .timer_out_n(tout_n), .compare_a_flag(fa),
      .period_match_flag(fp), .capture_value(cval),
      .capture_flag(cflag));
   ptm_pin_model pm (.aclk(aclk), .ext_clock_in(ext_clk),
      .capture_in(cap));
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // tallies of pulse outputs and of main pin high time
   always @(posedge aclk)
   begin
      na <= na + (fa === 1'b1);
      np <= np + (fp === 1'b1);
      nc <= nc + (cflag === 1'b1);
      hi <= hi + (tout === 1'b1);
      if (cflag === 1'b1)
         lastcap <= cval;
   end
   task automatic check(input string what, input logic [31:0] s, e);
      checks_done++;
      if (s !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // bounded wait: a hang counts as a mismatch
   task automatic limit(input int n);
      if (n >= 40)
      begin
         mismatches++;
         test_done;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v,
                     input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= {24'h0, v};
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awready)
            awv <= 1'b0;
         if (wready)
            wv <= 1'b0;
      end
      while (!bvalid && n < 40);
      limit(n);
      check("bresp", bresp, er);
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arready)
            arv <= 1'b0;
      end
      while (!rvalid && n < 40);
      limit(n);
      d = rdata;
      check("rresp", rresp, er);
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   // low byte to buffer first, high byte commits the pair
   task automatic setv(input logic [11:0] lo, input logic [9:0] v);
      wr(lo, v[7:0], `PTM_RESP_OKAY);
      wr(lo + 12'h004, {6'h0, v[9:8]}, `PTM_RESP_OKAY);
   endtask
   // timer switched off before mode or pin function change
   task automatic start(input logic [7:0] c1, c0);
      wr(`PTM_OFS_CTRL0, 8'h00, `PTM_RESP_OKAY);
      wr(`PTM_OFS_CTRL1, c1, `PTM_RESP_OKAY);
      wr(`PTM_OFS_CTRL0, c0, `PTM_RESP_OKAY);
   endtask
   task automatic wait_chg(ref int c, input int base);
      int n;
      n = 0;
      while (c == base && n < 40)
      begin
         @(posedge aclk);
         n++;
      end
      limit(n);
   endtask
   task automatic s_regs;
      rd(`PTM_OFS_CTRL1, `PTM_RESP_OKAY);
      check("ctrl1 reset", d, {24'h0, `PTM_CTRL1_RST});
      wr(`PTM_OFS_CTRL0, 8'h87, `PTM_RESP_OKAY);
      rd(`PTM_OFS_CTRL0, `PTM_RESP_OKAY);
      check("ctrl0 unused bits", d, 32'h80);
      wr(`PTM_OFS_CNT_HI, 8'h03, `PTM_RESP_OKAY);
      rd(`PTM_OFS_CNT_HI, `PTM_RESP_OKAY);
      check("count read only", d, 32'h0);
      wr(12'h020, 8'h5a, `PTM_RESP_SLVERR);
      rd(12'h020, `PTM_RESP_SLVERR);
      setv(`PTM_OFS_CMPA_LO, 10'h2a5);
      rd(`PTM_OFS_CMPA_HI, `PTM_RESP_OKAY);
      check("compare high", d, 32'h2);
      rd(`PTM_OFS_CMPA_LO, `PTM_RESP_OKAY);
      check("compare low", d, 32'ha5);
   endtask
   // every pin function with both initial levels, A clears
   task automatic s_cmp;
      logic [1:0] pf;
      logic       oc, ex;
      int         k;
      setv(`PTM_OFS_CMPA_LO, 10'd5);
      setv(`PTM_OFS_PER_LO, 10'd3);
      for (int i = 0; i < 8; i++)
      begin
         pf = i[2:1];
         oc = i[0];
         ex = (pf == 2'b00) ? oc : (pf == 2'b11) ? !oc : pf[1];
         start({2'b00, pf, oc, 3'b001}, 8'h18);
         check("initial level", tout, oc);
         k = np;
         wait_chg(na, na);
         repeat (2) @(posedge aclk);
         check("match level", tout, ex);
         check("no period flag", np, k);
      end
      // period clears before A is reached: pin must not move
      start(8'h38, 8'h18);
      k = na;
      wait_chg(np, np);
      repeat (40) @(posedge aclk);
      check("pin after period", tout, 1'b1);
      check("no A flag", na, k);
   endtask
   task automatic s_pwm;
      logic [7:0] c1 [6] = '{8'ha8, 8'hac, 8'ha8, 8'h88, 8'h98, 8'hb8};
      logic [9:0] ca [6] = '{10'd2, 10'd2, 10'd9, 10'd2, 10'd2, 10'd2};
      int         ex [6] = '{20, 60, 80, 0, 80, 0};
      int         h;
      setv(`PTM_OFS_PER_LO, 10'd8);
      for (int i = 0; i < 6; i++)
      begin
         setv(`PTM_OFS_CMPA_LO, ca[i]);
         start(c1[i], 8'h18);
         repeat (10) @(posedge aclk);
         h = hi;
         repeat (80) @(posedge aclk);
         check("pwm high time", hi - h, ex[i]);
      end
   endtask
   // capture edges, source select, counting on external edges
   task automatic s_cap;
      logic [7:0] c1 [5] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h42};
      logic [7:0] c0 [5] = '{8'h68, 8'h68, 8'h68, 8'h78, 8'h68};
      int         p [5] = '{3, 2, 1, 3, 2};
      int         er [5] = '{1, 0, 1, 0, 2};
      int         el [5] = '{1, 1, 2, 0, 2};
      int         ec [5] = '{3, 2, 1, 0, 1};
      int         k;
      for (int i = 0; i < 5; i++)
      begin
         start(c1[i], c0[i]);
         k = nc;
         pm.clk_pulses(p[i]);
         pm.cap_level(1'b1);
         check("captures on rise", nc - k, er[i]);
         pm.cap_level(1'b0);
         check("captures on fall", nc - k, el[i]);
         if (el[i] > 0)
            check("captured count", lastcap, ec[i]);
         rd(`PTM_OFS_CNT_HI, `PTM_RESP_OKAY);
         rd(`PTM_OFS_CNT_LO, `PTM_RESP_OKAY);
         check("count low byte", d, p[i]);
      end
   endtask
   // internal clock ratios, stop, hold and timer/counter pin
   task automatic s_clk;
      logic [2:0] sel [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
      int         ec [5] = '{160, 40, 10, 160, 160};
      logic [1:0] c;
      setv(`PTM_OFS_PER_LO, 10'd0);
      for (int i = 0; i < 5; i++)
      begin
         // 640 counted edges hold a whole number of every ratio
         start(8'hcc, {1'b0, sel[i], 4'h8});
         repeat (637) @(posedge aclk);
         wr(`PTM_OFS_CTRL0, {1'b0, sel[i], 4'h0}, `PTM_RESP_OKAY);
         check("timer mode pin", tout, 1'b0);
         repeat (20) @(posedge aclk);
         rd(`PTM_OFS_CNT_HI, `PTM_RESP_OKAY);
         c = d[1:0];
         rd(`PTM_OFS_CNT_LO, `PTM_RESP_OKAY);
         check("count ratio", {c, d[7:0]}, ec[i]);
      end
      // three edges counted before the hold, four after release
      start(8'hcc, 8'h18);
      wr(`PTM_OFS_CTRL0, 8'h98, `PTM_RESP_OKAY);
      repeat (20) @(posedge aclk);
      wr(`PTM_OFS_CTRL0, 8'h18, `PTM_RESP_OKAY);
      wr(`PTM_OFS_CTRL0, 8'h10, `PTM_RESP_OKAY);
      rd(`PTM_OFS_CNT_HI, `PTM_RESP_OKAY);
      rd(`PTM_OFS_CNT_LO, `PTM_RESP_OKAY);
      check("hold and resume", d, 32'h7);
   endtask
   initial
   begin
      aresetn = 1'b0;
      {awv, wv, bready, arv, rready} = 5'h0;
      awaddr = 12'h0;
      araddr = 12'h0;
      wdata = 32'h0;
      {mismatches, checks_done, na, np, nc, hi} = '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      s_regs;
      s_cmp;
      s_pwm;
      s_cap;
      s_clk;
      test_done;
   end
endmodule
`default_nettype wire

// ### ptm_consts.vh
// register offsets, field positions, reset values and clock ratios
// of the periodic timer; included by the timer module and the bench
`ifndef PTM_CONSTS_VH
`define PTM_CONSTS_VH
`define PTM_OFS_CTRL0    12'h000
`define PTM_OFS_CTRL1    12'h004
`define PTM_OFS_CNT_LO   12'h008
`define PTM_OFS_CNT_HI   12'h00c
`define PTM_OFS_CMPA_LO  12'h010
`define PTM_OFS_CMPA_HI  12'h014
`define PTM_OFS_PER_LO   12'h018
`define PTM_OFS_PER_HI   12'h01c
`define PTM_CTRL0_RST    8'h00
`define PTM_CTRL1_RST    8'h00
`define PTM_C0_HOLD      7
`define PTM_C0_ON        3
`define PTM_C1_OC        3
`define PTM_C1_POL       2
`define PTM_C1_CAPS      1
`define PTM_C1_CCLR      0
`define PTM_MODE_CMP     2'b00
`define PTM_MODE_CAP     2'b01
`define PTM_MODE_PWM     2'b10
`define PTM_MODE_TMR     2'b11
`define PTM_SYS_DIV      4
`define PTM_H_DIV16      16
`define PTM_H_DIV64      64
`define PTM_SUB_DIV      1526
`define PTM_RESP_OKAY    2'b00
`define PTM_RESP_SLVERR  2'b10
`endif

// ### ptm_edge_sync.v
// two-stage synchroniser with rise and fall pulses
// assumes the input is asynchronous to aclk
`timescale 1ns/100ps
`default_nettype none
module ptm_edge_sync
(
   input  wire aclk,
   input  wire aresetn,
   input  wire pin,
   output reg  rise,
   output reg  fall
);
   reg s1;
   reg s2;
   reg s3;
   // s1 feeds only s2; edges are taken from s2 and s3
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1   <= 1'b0;
         s2   <= 1'b0;
         s3   <= 1'b0;
         rise <= 1'b0;
         fall <= 1'b0;
      end
      else
      begin
         s1   <= pin;
         s2   <= s1;
         s3   <= s2;
         rise <= s2 & ~s3;
         fall <= ~s2 & s3;
      end
   end
endmodule
`default_nettype wire

// ### ptm_pin_model.sv
// far side of the timer: external count clock and capture pin
// driven from aclk edges; both lines rest low between uses
`timescale 1ns/100ps
`default_nettype none
module ptm_pin_model
(
   input  wire logic aclk,
   output var  logic ext_clock_in,
   output var  logic capture_in
);
   initial
   begin
      ext_clock_in = 1'b0;
      capture_in = 1'b0;
   end
   // each level held 4 cycles so the synchroniser sees it
   task automatic clk_pulses(input int n);
      repeat (n)
      begin
         repeat (4) @(posedge aclk);
         ext_clock_in <= 1'b1;
         repeat (4) @(posedge aclk);
         ext_clock_in <= 1'b0;
      end
      repeat (4) @(posedge aclk);
   endtask
   // slow level change, long enough for capture latency
   task automatic cap_level(input logic v);
      @(posedge aclk);
      capture_in <= v;
      repeat (10) @(posedge aclk);
   endtask
endmodule
`default_nettype wire

// ### ptm_timer.v
// periodic timer: 10-bit counter, two comparators, AXI4-Lite registers
// assumes external pins are asynchronous and are synchronised here
`timescale 1ns/100ps
`default_nettype none
`include "ptm_consts.vh"
module ptm_timer
#(
   parameter SUB_DIV = `PTM_SUB_DIV
)
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        ext_clock_in,
   input  wire        capture_in,
   output wire        timer_out,
   output wire        timer_out_n,
   output reg         compare_a_flag,
   output reg         period_match_flag,
   output reg  [9:0]  capture_value,
   output reg         capture_flag
);
   reg  [7:0]  timer_control_0;
   reg  [7:0]  timer_control_1;
   reg  [9:0]  count;
   reg  [9:0]  compare_a_value;
   reg  [9:0]  period_value;
   reg  [7:0]  low_buffer;
   reg         on_q;
   reg         pin_level;
   reg  [5:0]  div;
   reg  [10:0] sub_cnt;
   wire        ck_rise;
   wire        ck_fall;
   wire        cap_rise;
   wire        cap_fall;
   wire        count_hold  = timer_control_0[`PTM_C0_HOLD];
   wire [2:0]  count_clock_select = timer_control_0[6:4];
   wire        timer_on    = timer_control_0[`PTM_C0_ON];
   wire [1:0]  op_mode_select = timer_control_1[7:6];
   wire [1:0]  pin_function_select = timer_control_1[5:4];
   wire        output_initial_level = timer_control_1[`PTM_C1_OC];
   wire        output_invert = timer_control_1[`PTM_C1_POL];
   wire        capture_source_select = timer_control_1[`PTM_C1_CAPS];
   wire        clear_source_select = timer_control_1[`PTM_C1_CCLR];

   // external pins synchronised before any use
   ptm_edge_sync u_ck_sync (.aclk(aclk), .aresetn(aresetn),
      .pin(ext_clock_in), .rise(ck_rise), .fall(ck_fall));
   ptm_edge_sync u_cap_sync (.aclk(aclk), .aresetn(aresetn),
      .pin(capture_in), .rise(cap_rise), .fall(cap_fall));

   // prescalers; fH taken equal to aclk, fsub a slow divided tick
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div     <= 6'h00;
         sub_cnt <= 11'h000;
      end
      else
      begin
         div <= div + 6'h01;
         if (sub_cnt == SUB_DIV - 1)
            sub_cnt <= 11'h000;
         else
            sub_cnt <= sub_cnt + 11'h001;
      end
   end

   // count tick selection
   reg tick;
   always @*
   begin
      case (count_clock_select)
         3'h0:    tick = (div[1:0] == 2'h3);
         3'h1:    tick = 1'b1;
         3'h2:    tick = (div[3:0] == 4'hf);
         3'h3:    tick = (div == 6'h3f);
         3'h4,
         3'h5:    tick = (sub_cnt == SUB_DIV - 1);
         3'h6:    tick = ck_rise;
         3'h7:    tick = ck_fall;
         default: tick = 1'b0;
      endcase
   end

   // comparators and derived events
   wire        pwm_mode  = (op_mode_select == `PTM_MODE_PWM);
   wire        cap_mode  = (op_mode_select == `PTM_MODE_CAP);
   wire        cmp_mode  = (op_mode_select == `PTM_MODE_CMP);
   wire        match_a   = (count == compare_a_value);
   wire        per_zero  = (period_value == 10'h000);
   wire        ovf       = (count == 10'h3ff);
   wire        run       = timer_on & ~count_hold;
   wire        clr_a     = clear_source_select & ~pwm_mode & ~cap_mode;
   // period zero means counter rolls over at 3ff, giving 1024 counts
   wire        end_p     = per_zero ? ovf : (count == period_value - 10'h001);
   wire        clear_now = clr_a ? (match_a & compare_a_value != 10'h000)
                                 : (end_p | ovf);
   wire        a_event   = run & tick & (count + 10'h001 == compare_a_value)
                           & (compare_a_value != 10'h000);
   wire        p_event   = run & tick & ~clr_a & end_p;
   wire        on_rise   = timer_on & ~on_q;

   // counter, edge tracking and match flags
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count             <= 10'h000;
         on_q              <= 1'b0;
         compare_a_flag    <= 1'b0;
         period_match_flag <= 1'b0;
      end
      else
      begin
         on_q              <= timer_on;
         compare_a_flag    <= a_event;
         period_match_flag <= p_event;
         if (on_rise)
            count <= 10'h000;
         else if (run & tick)
         begin
            if (clear_now)
               count <= 10'h000;
            else
               count <= count + 10'h001;
         end
      end
   end

   // compare-mode pin state; only compare A events act on it
   always @(posedge aclk)
   begin
      if (!aresetn)
         pin_level <= 1'b0;
      else if (on_rise)
         pin_level <= output_initial_level;
      else if (cmp_mode & a_event)
      begin
         case (pin_function_select)
            2'h1:    pin_level <= 1'b0;
            2'h2:    pin_level <= 1'b1;
            2'h3:    pin_level <= ~pin_level;
            default: pin_level <= pin_level;
         endcase
      end
   end

   // pwm: active while count below duty; duty >= period is 100 percent
   wire [10:0] per_len = per_zero ? 11'h400 : {1'b0, period_value};
   wire        pwm_act = ({1'b0, compare_a_value} >= per_len) |
                         (count < compare_a_value);
   reg raw_out;
   always @*
   begin
      if (pwm_mode)
      begin
         case (pin_function_select)
            2'h0:    raw_out = ~output_initial_level;
            2'h1:    raw_out = output_initial_level;
            2'h2:    raw_out = ~(pwm_act ^ output_initial_level);
            default: raw_out = ~output_initial_level;
         endcase
      end
      else if (cmp_mode)
         raw_out = pin_level;
      else
         raw_out = 1'b0; // undefined level held low
   end
   // polarity has no effect in timer/counter mode
   assign timer_out   = (op_mode_select == `PTM_MODE_TMR) ? 1'b0
                      : raw_out ^ output_invert;
   assign timer_out_n = ~timer_out;

   // capture of the count on the chosen edge
   wire src_rise = capture_source_select ? ck_rise : cap_rise;
   wire src_fall = capture_source_select ? ck_fall : cap_fall;
   reg  cap_hit;
   always @*
   begin
      case (pin_function_select)
         2'h0:    cap_hit = src_rise;
         2'h1:    cap_hit = src_fall;
         2'h2:    cap_hit = src_rise | src_fall;
         default: cap_hit = 1'b0;
      endcase
   end
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         capture_value <= 10'h000;
         capture_flag  <= 1'b0;
      end
      else
      begin
         capture_flag <= cap_mode & timer_on & cap_hit;
         if (cap_mode & timer_on & cap_hit)
            capture_value <= count;
      end
   end

   // AXI4-Lite write: address and data taken in either order
   reg        aw_held;
   reg        w_held;
   reg [11:0] aw_addr;
   reg [7:0]  w_byte;
   reg        w_lane;
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   wire wr_go = aw_held & w_held;
   wire rd_take = s_axi_arvalid & s_axi_arready;
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held         <= 1'b0;
         w_held          <= 1'b0;
         aw_addr         <= 12'h000;
         w_byte          <= 8'h00;
         w_lane          <= 1'b0;
         s_axi_bvalid    <= 1'b0;
         s_axi_bresp     <= `PTM_RESP_OKAY;
         timer_control_0 <= `PTM_CTRL0_RST;
         timer_control_1 <= `PTM_CTRL1_RST;
         compare_a_value <= 10'h000;
         period_value    <= 10'h000;
         low_buffer      <= 8'h00;
      end
      else
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
         end
         if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
         // high-byte read latches its low byte; a write below wins
         if (rd_take & (s_axi_araddr == `PTM_OFS_CNT_HI))
            low_buffer <= count[7:0];
         if (rd_take & (s_axi_araddr == `PTM_OFS_CMPA_HI))
            low_buffer <= compare_a_value[7:0];
         if (rd_take & (s_axi_araddr == `PTM_OFS_PER_HI))
            low_buffer <= period_value[7:0];
         if (wr_go)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `PTM_RESP_OKAY;
            // only byte lane 0 carries data; other lanes are ignored
            if (w_lane)
            begin
               case (aw_addr)
                  `PTM_OFS_CTRL0:   timer_control_0 <= {w_byte[7:3], 3'h0};
                  `PTM_OFS_CTRL1:   timer_control_1 <= w_byte;
                  `PTM_OFS_CMPA_LO,
                  `PTM_OFS_PER_LO:  low_buffer <= w_byte;
                  `PTM_OFS_CMPA_HI: compare_a_value <= {w_byte[1:0],
                                                        low_buffer};
                  `PTM_OFS_PER_HI:  period_value <= {w_byte[1:0],
                                                     low_buffer};
                  `PTM_OFS_CNT_LO,
                  `PTM_OFS_CNT_HI:  s_axi_bresp <= `PTM_RESP_OKAY;
                  default:          s_axi_bresp <= `PTM_RESP_SLVERR;
               endcase
            end
         end
      end
   end

   // AXI4-Lite read; high-byte reads load the shared low buffer
   reg [7:0] rd_byte;
   reg       rd_ok;
   assign s_axi_arready = ~s_axi_rvalid;
   always @*
   begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `PTM_OFS_CTRL0:   rd_byte = {timer_control_0[7:3], 3'h0};
         `PTM_OFS_CTRL1:   rd_byte = timer_control_1;
         `PTM_OFS_CNT_LO,
         `PTM_OFS_CMPA_LO,
         `PTM_OFS_PER_LO:  rd_byte = low_buffer;
         `PTM_OFS_CNT_HI:  rd_byte = {6'h00, count[9:8]};
         `PTM_OFS_CMPA_HI: rd_byte = {6'h00, compare_a_value[9:8]};
         `PTM_OFS_PER_HI:  rd_byte = {6'h00, period_value[9:8]};
         default:
         begin
            rd_byte = 8'h00;
            rd_ok   = 1'b0;
         end
      endcase
   end
   // read answer; the shared buffer is loaded in the write process
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `PTM_RESP_OKAY;
      end
      else if (rd_take)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h000000, rd_byte};
         s_axi_rresp  <= rd_ok ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule
`default_nettype wire

// ### ptm_timer_monitor.sv
// port checker for the periodic timer
// bound onto ptm_timer, sees its ports only
`timescale 1ns/100ps
`default_nettype none
module ptm_timer_mon
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic       timer_out,
   input wire logic       timer_out_n,
   input wire logic [9:0] capture_value,
   input wire logic       capture_flag
);
   // one clock domain, so shared clocking and disable
   default clocking mcb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_out_inverse: assert property (timer_out_n == !timer_out)
      else $error("inverse pin differs");
   a_bvalid_stands: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_rvalid_stands: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer dropped");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_refused: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_write_refused: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   // a stored count only moves together with its event pulse
   a_capture_cause: assert property (
      !$stable(capture_value) |-> capture_flag)
      else $error("capture value moved alone");
endmodule
bind ptm_timer ptm_timer_mon u_mon (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .timer_out, .timer_out_n, .capture_value,
   .capture_flag);
`default_nettype wire
